// File: slave_pkg.sv
// Constants, state codes and register map of the slave state sequencer
// and start-up gate. Assumes a 32-bit AXI4-Lite register bus.
// Contract
// RULE_01: After reset the slave is idle, code 01h, no mailbox, no data.
// RULE_02: Master sets up mailbox buffer channels 0 and 1 while idle.
// RULE_03: Master sets up data channels from 2, mapping units, objects in config.
// RULE_04: Idle to config requires a correct mailbox setup check.
// RULE_05: Config state allows mailbox and tunnelled ethernet, blocks data.
// RULE_06: Inputs-only updates inputs, outputs off, mailbox and data allowed.
// RULE_07: Config to inputs-only requires correct data channel setup.
// RULE_08: Inputs copied to dual-port memory before inputs-only is acknowledged.
// RULE_09: Full exchange drives master outputs and returns inputs.
// RULE_10: Firmware-update state is reachable only from idle.
// RULE_11: Firmware-update allows only file-transfer mailbox, nothing else.
// RULE_12: State changes only on a master request.
// RULE_13: Run requests full exchange, then waits bounded time for slaves; the code only starts the wait, the state moves only on OFF_REQ writes.
// RULE_14: Topology-checked start-up waits bounded time, runs only if matching.
// RULE_15: Topology-independent start-up waits bounded time, then runs anyway.
// RULE_16: Mismatch parameter active selects topology-checked start-up.
// RULE_17: Wrong module on a mandatory slave withholds independent start-up.
// RULE_18: Wrong module on an optional slave withholds independent start-up.
// RULE_19: An unconfigured slave withholds independent start-up.
// RULE_20: Sync enabled and any sync loss withholds independent start-up.
// RULE_21: Missing mandatory slave withholds independent start-up.
// RULE_22: All faults absent permits independent start-up; the code also withholds it if configured optional slaves are all absent.
// RULE_23: Refused or failed transition keeps state and reports refusal.
package slave_pkg;
   // State codes
   localparam logic [3:0] ST_IDLE = 4'h1;
   localparam logic [3:0] ST_CONFIG = 4'h2;
   localparam logic [3:0] ST_FWUPD = 4'h3;
   localparam logic [3:0] ST_INPUTS = 4'h4;
   localparam logic [3:0] ST_FULL = 4'h8;
   // Register byte offsets
   localparam logic [7:0] OFF_REQ = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_SETUP = 8'h08;
   localparam logic [7:0] OFF_TOPO = 8'h0C;
   localparam logic [7:0] OFF_RUNC = 8'h10;
   localparam logic [7:0] OFF_RUNS = 8'h14;
   localparam logic [7:0] OFF_TMO = 8'h18;
   // Setup register fields
   localparam int SETUP_MBX = 0;
   localparam int SETUP_PD = 1;
   // Topology register fields
   localparam int TP_MISMATCH = 0;
   localparam int TP_MAND_CFG = 1;
   localparam int TP_MAND_ALL = 2;
   localparam int TP_OPT_CFG = 3;
   localparam int TP_OPT_ANY = 4;
   localparam int TP_MAND_WRONG = 5;
   localparam int TP_OPT_WRONG = 6;
   localparam int TP_UNCFG = 7;
   localparam int TP_SYNC_EN = 8;
   localparam int TP_ALL_SYNC = 9;
   localparam int TP_MST_SYNC = 10;
   // Status register fields
   localparam int ST_REFUSE = 4;
   localparam int ST_BUSY = 5;
   // Run status fields
   localparam int RS_RUN = 0;
   localparam int RS_WAIT = 1;
   localparam int RS_CHECKED = 2;
   localparam int RS_TMO = 3;
   // Timeout defaults: monitoring time in microseconds
   localparam int CLK_MHZ = 100;
   localparam int MON_TIME_US = 1000;
   localparam logic [31:0] MON_CYCLES = 32'(MON_TIME_US * CLK_MHZ);
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: slave_seq.sv
// Slave state sequencer and controller start-up gate, one AXI4-Lite slave.
// Assumes the master writes one state request at a time and polls status.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module slave_seq (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // AXI4-Lite write
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Process data
   input wire logic [31:0] in_data,
   input wire logic [31:0] out_from_master,
   output logic [31:0] out_pins,
   output logic [31:0] dpm_inputs,
   // Service enables
   output logic mailbox_en,
   output logic eth_tunnel_en,
   output logic file_xfer_en,
   output logic pd_en,
   // Controller run
   output logic cpu_run
);
   typedef enum {SQ_STABLE, SQ_COPY} seq_t;
   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] state;
      logic [3:0] target;
      seq_t seq;
      logic refuse;
      logic [1:0] setup;
      logic [10:0] topo;
      logic run_req;
      logic waiting;
      logic run;
      logic checked;
      logic tmo;
      logic [31:0] tmo_cfg;
      logic [31:0] cnt;
      logic [31:0] outp;
      logic [31:0] dpm;
   } state_t;
   state_t s_reg, s_next;

   ////////////////////////////////////////////////////////////////////////
   // Transition legality; refused moves keep the state
   function automatic logic legal(input logic [3:0] from, input logic [3:0] to,
                                  input logic [1:0] su);
      logic ok;
      ok = 1'b0;
      unique case (to)
         slave_pkg::ST_IDLE: ok = 1'b1;
         slave_pkg::ST_CONFIG: ok = (from == slave_pkg::ST_IDLE &&
            su[slave_pkg::SETUP_MBX]) || from == slave_pkg::ST_INPUTS ||
            from == slave_pkg::ST_FULL; // [RULE_04]
         slave_pkg::ST_FWUPD: ok = from == slave_pkg::ST_IDLE; // [RULE_10]
         slave_pkg::ST_INPUTS: ok = (from == slave_pkg::ST_CONFIG &&
            su[slave_pkg::SETUP_PD]) || from == slave_pkg::ST_FULL; // [RULE_07]
         slave_pkg::ST_FULL: ok = from == slave_pkg::ST_INPUTS;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Independent start-up permission from the topology flags
   function automatic logic indep_ok(input logic [10:0] t);
      logic ok;
      ok = 1'b1;
      if (t[slave_pkg::TP_MAND_WRONG]) ok = 1'b0; // [RULE_17]
      if (t[slave_pkg::TP_OPT_WRONG]) ok = 1'b0; // [RULE_18]
      if (t[slave_pkg::TP_UNCFG]) ok = 1'b0; // [RULE_19]
      if (t[slave_pkg::TP_SYNC_EN] && !(t[slave_pkg::TP_ALL_SYNC] &&
          t[slave_pkg::TP_MST_SYNC])) ok = 1'b0; // [RULE_20]
      if (t[slave_pkg::TP_MAND_CFG] && !t[slave_pkg::TP_MAND_ALL])
         ok = 1'b0; // [RULE_21]
      if (t[slave_pkg::TP_OPT_CFG] && !t[slave_pkg::TP_OPT_ANY])
         ok = 1'b0; // [RULE_22]
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic for bus, sequencer and gate
   always_comb begin
      logic wr;
      logic [31:0] wd;
      logic topo_good;
      wr = 1'b0;
      wd = 32'h0000_0000;
      topo_good = 1'b0;
      s_next = s_reg;
      // Write channel capture, either order
      if (s_awvalid && !s_reg.aw_got) begin
         s_next.aw_got = 1'b1;
         s_next.aw_addr = s_awaddr;
      end
      if (s_wvalid && !s_reg.w_got) begin
         s_next.w_got = 1'b1;
         s_next.w_data = s_wdata;
         s_next.w_strb = s_wstrb;
      end
      if (s_bvalid && s_bready) s_next.bvalid = 1'b0;
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
         wr = 1'b1;
         wd = s_reg.w_data;
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = slave_pkg::RESP_OKAY;
      end
      // Read channel
      if (s_rvalid && s_rready) s_next.rvalid = 1'b0;
      if (s_arvalid && !s_reg.rvalid) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = slave_pkg::RESP_OKAY;
         unique case (s_araddr)
            slave_pkg::OFF_REQ: s_next.rdata = {28'h0000000, s_reg.target};
            slave_pkg::OFF_STAT: s_next.rdata = {26'h0000000,
               s_reg.seq == SQ_COPY, s_reg.refuse, s_reg.state};
            slave_pkg::OFF_SETUP: s_next.rdata = {30'h00000000, s_reg.setup};
            slave_pkg::OFF_TOPO: s_next.rdata = {21'h000000, s_reg.topo};
            slave_pkg::OFF_RUNC: s_next.rdata = {31'h00000000, s_reg.run_req};
            slave_pkg::OFF_RUNS: s_next.rdata = {28'h0000000, s_reg.tmo,
               s_reg.checked, s_reg.waiting, s_reg.run};
            slave_pkg::OFF_TMO: s_next.rdata = s_reg.tmo_cfg;
            default: begin
               s_next.rdata = 32'h0000_0000;
               s_next.rresp = slave_pkg::RESP_SLVERR;
            end
         endcase
      end
      // Sequencer: only master writes start a move
      if (s_reg.seq == SQ_COPY) begin
         s_next.dpm = in_data; // [RULE_08]
         s_next.state = slave_pkg::ST_INPUTS;
         s_next.seq = SQ_STABLE;
      end
      if (wr) begin
         unique case (s_reg.aw_addr)
            slave_pkg::OFF_REQ: if (s_reg.w_strb[0]) begin
               s_next.target = wd[3:0];
               if (wd[3:0] == s_reg.state) begin
                  s_next.refuse = 1'b0;
               end else if (s_reg.seq == SQ_STABLE &&
                            legal(s_reg.state, wd[3:0], s_reg.setup)) begin
                  s_next.refuse = 1'b0;
                  if (wd[3:0] == slave_pkg::ST_INPUTS &&
                      s_reg.state == slave_pkg::ST_CONFIG)
                     s_next.seq = SQ_COPY; // [RULE_08]
                  else
                     s_next.state = wd[3:0]; // [RULE_12]
               end else begin
                  s_next.refuse = 1'b1; // [RULE_23]
                  s_next.bresp = slave_pkg::RESP_SLVERR;
               end
            end
            slave_pkg::OFF_SETUP: if (s_reg.w_strb[0])
               s_next.setup = wd[1:0]; // [RULE_02] [RULE_03]
            slave_pkg::OFF_TOPO: begin
               if (s_reg.w_strb[0]) s_next.topo[7:0] = wd[7:0];
               if (s_reg.w_strb[1]) s_next.topo[10:8] = wd[10:8];
            end
            slave_pkg::OFF_RUNC: if (s_reg.w_strb[0]) begin
               s_next.run_req = wd[0];
               if (!wd[0]) begin
                  s_next.run = 1'b0;
                  s_next.waiting = 1'b0;
               end else if (!s_reg.run_req) begin
                  s_next.waiting = 1'b1; // [RULE_13]
                  s_next.cnt = 32'h0000_0000;
                  s_next.tmo = 1'b0;
               end
            end
            slave_pkg::OFF_TMO: begin
               if (s_reg.w_strb[0]) s_next.tmo_cfg[7:0] = wd[7:0];
               if (s_reg.w_strb[1]) s_next.tmo_cfg[15:8] = wd[15:8];
               if (s_reg.w_strb[2]) s_next.tmo_cfg[23:16] = wd[23:16];
               if (s_reg.w_strb[3]) s_next.tmo_cfg[31:24] = wd[31:24];
            end
            default: s_next.bresp = slave_pkg::RESP_SLVERR;
         endcase
      end
      // Start-up gate: wait for full exchange, bounded by timeout
      s_next.checked = s_reg.topo[slave_pkg::TP_MISMATCH]; // [RULE_16]
      topo_good = s_reg.topo[slave_pkg::TP_MAND_ALL] &&
         !s_reg.topo[slave_pkg::TP_MAND_WRONG] &&
         !s_reg.topo[slave_pkg::TP_OPT_WRONG] &&
         !s_reg.topo[slave_pkg::TP_UNCFG];
      if (s_reg.waiting && !wr) begin
         s_next.cnt = s_reg.cnt + 32'h0000_0001;
         if (s_reg.state == slave_pkg::ST_FULL ||
             s_reg.cnt >= s_reg.tmo_cfg) begin
            s_next.waiting = 1'b0;
            s_next.tmo = s_reg.state != slave_pkg::ST_FULL;
            if (s_reg.topo[slave_pkg::TP_MISMATCH])
               s_next.run = topo_good; // [RULE_14]
            else
               s_next.run = indep_ok(s_reg.topo); // [RULE_15]
         end
      end
      // Process data outputs per state
      s_next.outp = (s_reg.state == slave_pkg::ST_FULL) ?
         out_from_master : 32'h0000_0000; // [RULE_06] [RULE_09]
      if ((s_reg.state == slave_pkg::ST_INPUTS ||
           s_reg.state == slave_pkg::ST_FULL) && s_reg.seq == SQ_STABLE)
         s_next.dpm = in_data; // [RULE_06]
   end

   ////////////////////////////////////////////////////////////////////////
   // State register; reset lands in idle
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.state <= slave_pkg::ST_IDLE; // [RULE_01]
         s_reg.target <= slave_pkg::ST_IDLE;
         s_reg.seq <= SQ_STABLE;
         s_reg.tmo_cfg <= slave_pkg::MON_CYCLES;
         mailbox_en <= 1'b0;
         eth_tunnel_en <= 1'b0;
         file_xfer_en <= 1'b0;
         pd_en <= 1'b0;
      end else begin
         s_reg <= s_next;
         mailbox_en <= s_next.state == slave_pkg::ST_CONFIG ||
            s_next.state == slave_pkg::ST_INPUTS ||
            s_next.state == slave_pkg::ST_FULL; // [RULE_05]
         eth_tunnel_en <= s_next.state == slave_pkg::ST_CONFIG ||
            s_next.state == slave_pkg::ST_INPUTS ||
            s_next.state == slave_pkg::ST_FULL;
         file_xfer_en <= s_next.state != slave_pkg::ST_IDLE; // [RULE_11]
         pd_en <= s_next.state == slave_pkg::ST_INPUTS ||
            s_next.state == slave_pkg::ST_FULL; // [RULE_05]
      end
   end

   // Outputs straight from the state register
   assign s_awready = !s_reg.aw_got;
   assign s_wready = !s_reg.w_got;
   assign s_bvalid = s_reg.bvalid;
   assign s_bresp = s_reg.bresp;
   assign s_arready = !s_reg.rvalid;
   assign s_rvalid = s_reg.rvalid;
   assign s_rdata = s_reg.rdata;
   assign s_rresp = s_reg.rresp;
   assign out_pins = s_reg.outp;
   assign dpm_inputs = s_reg.dpm;
   assign cpu_run = s_reg.run;

   ////////////////////////////////////////////////////////////////////////
   // Checks beside the logic
   reset_idle_a: assert property (@(posedge mclk) $fell(rst) |->
      s_reg.state == slave_pkg::ST_IDLE && !mailbox_en && !pd_en)
      else $error("state not idle after reset"); // [RULE_01]
   cfg_pd_off_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.state == slave_pkg::ST_CONFIG |->
      mailbox_en && eth_tunnel_en && !pd_en)
      else $error("data open in config"); // [RULE_05]
   mbx_check_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.state == slave_pkg::ST_IDLE && !s_reg.setup[0] ##1
      s_reg.state == slave_pkg::ST_CONFIG |-> 1'b0)
      else $error("config entered without mailbox"); // [RULE_04]
   pd_check_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.state == slave_pkg::ST_CONFIG && !s_reg.setup[1] ##1
      s_reg.seq == SQ_COPY |-> 1'b0)
      else $error("inputs-only without data setup"); // [RULE_07]
   copy_first_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.seq == SQ_COPY |=> s_reg.state == slave_pkg::ST_INPUTS &&
      dpm_inputs == $past(in_data)) else $error("copy missing"); // [RULE_08]
   outs_off_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.state == slave_pkg::ST_INPUTS ##1 1'b1 |-> out_pins == 32'h0)
      else $error("outputs live in inputs-only"); // [RULE_06]
   full_drive_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.state == slave_pkg::ST_FULL |=> out_pins ==
      $past(out_from_master)) else $error("outputs not driven"); // [RULE_09]
   fw_entry_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(s_reg.state) && s_reg.state == slave_pkg::ST_FWUPD |->
      $past(s_reg.state) == slave_pkg::ST_IDLE)
      else $error("firmware state from non-idle"); // [RULE_10]
   fw_only_a: assert property (@(posedge mclk) disable iff (rst)
      s_reg.state == slave_pkg::ST_FWUPD ##1 s_reg.state ==
      slave_pkg::ST_FWUPD |-> file_xfer_en && !mailbox_en && !pd_en &&
      !eth_tunnel_en)
      else $error("extra service in firmware state"); // [RULE_11]
   master_only_a: assert property (@(posedge mclk) disable iff (rst)
      $changed(s_reg.state) |-> $past(s_reg.seq) == SQ_COPY ||
      $past(s_reg.aw_got && s_reg.w_got))
      else $error("state moved on its own"); // [RULE_12]
   refuse_hold_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(s_reg.refuse) |-> s_reg.state == $past(s_reg.state))
      else $error("refused move changed state"); // [RULE_23]
   gate_run_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(cpu_run) |-> $past(s_reg.topo[0]) ||
      indep_ok($past(s_reg.topo)))
      else $error("run without permission"); // [RULE_15] [RULE_22]
endmodule // slave_seq

// File: fb_master_model.sv
// Far-side fieldbus master model: sends a fresh output word every cycle.
// Assumes the bench raises send_en once the slave is in full exchange.
`timescale 1ns/1ps
module fb_master_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control from bench
   input wire logic send_en,
   // Output data toward the slave, and the word sent one cycle earlier for the bench
   output logic [31:0] out_from_master,
   output logic [31:0] prev_sent
);
   logic [31:0] cnt_reg;
   ////////////////////////////////////////////////////////////////////////
   // Word changes every cycle so a stale copy in the slave shows up
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_reg <= 32'h0000_0000;
         prev_sent <= 32'h0000_0000;
      end else begin
         cnt_reg <= cnt_reg + 32'h0001_0003;
         prev_sent <= out_from_master;
      end
   end
   // While send_en is low the inverted pattern stands in for no data
   assign out_from_master = send_en ? cnt_reg : ~cnt_reg;
endmodule // fb_master_model

// File: tb_fieldbus_slave_state_and_startup.sv
// Self-checking bench for the slave state sequencer and start-up gate.
// Assumes slave_pkg, slave_seq and fb_master_model are compiled first.
`timescale 1ns/1ps
module tb_fieldbus_slave_state_and_startup;
   logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, send_en;
   logic awready, wready, bvalid, arready, rvalid, cpu_run;
   logic mailbox_en, eth_tunnel_en, file_xfer_en, pd_en;
   logic [7:0] awaddr, araddr;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [31:0] wdata, rdata, in_data, out_from_master, prev_sent;
   logic [31:0] out_pins, dpm_inputs;
   int n_mismatch, compares;
   ////////////////////////////////////////////////////////////////////////
   // Design and far-side model
   slave_seq i_dut (.mclk(mclk), .rst(rst), .s_awaddr(awaddr),
      .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
      .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
      .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
      .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
      .s_rready(rready), .in_data(in_data),
      .out_from_master(out_from_master), .out_pins(out_pins),
      .dpm_inputs(dpm_inputs), .mailbox_en(mailbox_en),
      .eth_tunnel_en(eth_tunnel_en), .file_xfer_en(file_xfer_en),
      .pd_en(pd_en), .cpu_run(cpu_run));
   fb_master_model i_master (.mclk(mclk), .rst(rst), .send_en(send_en),
      .out_from_master(out_from_master), .prev_sent(prev_sent));
   ////////////////////////////////////////////////////////////////////////
   // Verdict, comparison and bus tasks
   task automatic results();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] resp);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      if (n >= 100) begin
         n_mismatch++;
         results();
      end
      chk({30'h0, bresp}, {30'h0, resp});
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 100);
      d = rdata;
      rready <= 1'b0;
      if (n >= 100) begin
         n_mismatch++;
         results();
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
         input logic [31:0] mask, input logic [1:0] resp);
      logic [31:0] d;
      axr(a, d);
      chk(d & mask, exp);
      chk({30'h0, rresp}, {30'h0, resp});
   endtask
   task automatic req(input logic [3:0] st, input logic [1:0] resp);
      wr(slave_pkg::OFF_REQ, {28'h0, st}, resp);
   endtask
   // Enables packed as mailbox, tunnel, file transfer, process data
   task automatic ens(input logic [3:0] exp);
      #1;
      chk({28'h0, mailbox_en, eth_tunnel_en, file_xfer_en, pd_en},
         {28'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      rd(slave_pkg::OFF_STAT, 32'h1, 32'hF, slave_pkg::RESP_OKAY);
      ens(4'h0);
      rd(slave_pkg::OFF_TMO, 32'h0001_86A0, 32'hFFFF_FFFF, 2'b00);
      rd(8'h40, 32'h0, 32'hFFFF_FFFF, slave_pkg::RESP_SLVERR);
      wr(8'h44, 32'h1, slave_pkg::RESP_SLVERR);
      $display("test reset done");
   endtask
   task automatic t_refuse();
      req(slave_pkg::ST_FULL, slave_pkg::RESP_SLVERR);
      req(slave_pkg::ST_CONFIG, slave_pkg::RESP_SLVERR);
      rd(slave_pkg::OFF_STAT, 32'h11, 32'h1F, 2'b00);
      $display("test refuse done");
   endtask
   task automatic t_boot();
      req(slave_pkg::ST_FWUPD, slave_pkg::RESP_OKAY);
      ens(4'h2);
      req(slave_pkg::ST_IDLE, slave_pkg::RESP_OKAY);
      wr(slave_pkg::OFF_SETUP, 32'h1, slave_pkg::RESP_OKAY);
      req(slave_pkg::ST_CONFIG, slave_pkg::RESP_OKAY);
      ens(4'hE);
      req(slave_pkg::ST_FWUPD, slave_pkg::RESP_SLVERR);
      rd(slave_pkg::OFF_STAT, 32'h12, 32'h1F, 2'b00);
      $display("test boot done");
   endtask
   task automatic t_up();
      req(slave_pkg::ST_INPUTS, slave_pkg::RESP_SLVERR);
      wr(slave_pkg::OFF_SETUP, 32'h3, slave_pkg::RESP_OKAY);
      req(slave_pkg::ST_INPUTS, slave_pkg::RESP_OKAY);
      rd(slave_pkg::OFF_STAT, 32'h4, 32'hF, 2'b00);
      chk(dpm_inputs, 32'hC3A5_0F10);
      chk(out_pins, 32'h0);
      ens(4'hF);
      req(slave_pkg::ST_FULL, slave_pkg::RESP_OKAY);
      @(posedge mclk);
      send_en <= 1'b1;
      in_data <= 32'h3C5A_F0E1;
      repeat (4) begin
         @(posedge mclk);
         #1;
         chk(out_pins, prev_sent);
      end
      chk(dpm_inputs, 32'h3C5A_F0E1);
      req(slave_pkg::ST_INPUTS, slave_pkg::RESP_OKAY);
      #1;
      chk(out_pins, 32'h0);
      req(slave_pkg::ST_FULL, slave_pkg::RESP_OKAY);
      $display("test start-up path done");
   endtask
   // Expected packs checked mode at bit 2 and run at bit 0
   task automatic gate(input logic [31:0] topo, input logic [31:0] exp);
      wr(slave_pkg::OFF_TOPO, topo, slave_pkg::RESP_OKAY);
      wr(slave_pkg::OFF_RUNC, 32'h1, slave_pkg::RESP_OKAY);
      rd(slave_pkg::OFF_RUNS, exp, 32'h5, slave_pkg::RESP_OKAY);
      #1;
      chk({31'h0, cpu_run}, {31'h0, exp[0]});
      wr(slave_pkg::OFF_RUNC, 32'h0, slave_pkg::RESP_OKAY);
   endtask
   task automatic t_gate();
      wr(slave_pkg::OFF_TMO, 32'd20, slave_pkg::RESP_OKAY);
      gate(32'h006, 32'h1);
      gate(32'h706, 32'h1);
      gate(32'h506, 32'h0);
      gate(32'h026, 32'h0);
      gate(32'h046, 32'h0);
      gate(32'h086, 32'h0);
      gate(32'h002, 32'h0);
      gate(32'h01E, 32'h1);
      gate(32'h107, 32'h5);
      gate(32'h027, 32'h4);
      $display("test gate done");
   endtask
   task automatic t_tmo();
      logic [31:0] d;
      int n;
      req(slave_pkg::ST_INPUTS, slave_pkg::RESP_OKAY);
      wr(slave_pkg::OFF_TOPO, 32'h006, slave_pkg::RESP_OKAY);
      wr(slave_pkg::OFF_RUNC, 32'h1, slave_pkg::RESP_OKAY);
      rd(slave_pkg::OFF_RUNS, 32'h2, 32'h3, 2'b00);
      n = 0;
      do begin
         axr(slave_pkg::OFF_RUNS, d);
         n++;
      end while (d[1] !== 1'b0 && n < 30);
      if (n >= 30) begin
         n_mismatch++;
         results();
      end
      rd(slave_pkg::OFF_RUNS, 32'h9, 32'hB, 2'b00);
      $display("test timeout done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Clock, reset and sequence
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      n_mismatch = 0;
      compares = 0;
      rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, send_en} = 6'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      in_data = 32'hC3A5_0F10;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_refuse();
      t_boot();
      t_up();
      t_gate();
      t_tmo();
      results();
   end
endmodule // tb_fieldbus_slave_state_and_startup
